/* File: rtl/ascr_hist_mem.sv */
// Sample history memory with registered read data
module ascr_hist_mem #(
	parameter int WIDTH      = 16,
	parameter int DEPTH_LOG2 = 8
) (
	input  logic                  clk,
	input  logic                  rst,
	input  logic                  en,
	input  logic [DEPTH_LOG2-1:0] addr,
	input  logic [WIDTH-1:0]      wdata,
	output logic [WIDTH-1:0]      rdata
);
	logic [WIDTH-1:0] mem [2**DEPTH_LOG2];

	// Read before write: the slot about to be overwritten holds the oldest sample
	always_ff @(posedge clk) begin
		if (en) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (en) begin
			rdata <= mem[addr];
		end
	end
endmodule // ascr_hist_mem

/* File: rtl/ascr_map.svh */
// Offsets, field positions, reset values and timing counts of the angle readout block
`ifndef ASCR_MAP_SVH
`define ASCR_MAP_SVH
`define ASCR_WORD_BITS        16
`define ASCR_OP_WRITE         4'h2
`define ASCR_OP_READ          4'h1
`define ASCR_ADDR_BIAS        4'h3
`define ASCR_ADDR_ZERO_HIGH   4'h4
`define ASCR_ADDR_ZERO_LOW    4'h5
`define ASCR_REG_COUNT        3
`define ASCR_IDX_BIAS         0
`define ASCR_IDX_ZERO_HIGH    1
`define ASCR_IDX_ZERO_LOW     2
`define ASCR_REG_RESET        8'h00
`define ASCR_FULL_MASK        8'hFF
`define ASCR_ZERO_LOW_MASK    8'h3F
`define ASCR_X_TRIM_BIT       4
`define ASCR_Y_TRIM_BIT       5
`define ASCR_ZERO_PAD_BITS    4
`define ASCR_CLK_PERIOD_NS    10
`define ASCR_SAMPLE_PERIOD_NS 2000
`define ASCR_SAMPLE_CYCLES    (`ASCR_SAMPLE_PERIOD_NS / `ASCR_CLK_PERIOD_NS)
`define ASCR_SPEED_WIN_LOG2   8
`define ASCR_SECTORS          6
`endif

/* File: rtl/ascr_pkg.sv */
// Types shared by the angle readout block
package ascr_pkg;
	typedef logic [15:0] ascr_angle_t;
	typedef logic [7:0]  ascr_byte_t;
	typedef enum logic {boot_load, boot_run} ascr_boot_t;
	typedef struct packed {
		ascr_boot_t      boot;
		logic            cs_s1;
		logic            cs_s2;
		logic            tog_s1;
		logic            tog_s2;
		logic            tog_seen;
		logic [2:0]      lock;
		logic [2:0][7:0] regs;
		logic [11:0]     tick;
		logic [7:0]      ptr;
		logic            filled;
		logic            calc;
		ascr_angle_t     raw;
		ascr_angle_t     est;
		ascr_angle_t     angle;
		ascr_angle_t     out_buf;
		logic [9:0]      enc_pos;
		logic            enc_a;
		logic            enc_b;
		logic            enc_z;
		logic            com_u;
		logic            com_v;
		logic            com_w;
	} ascr_core_t;
	typedef struct packed {
		logic [4:0]  cnt;
		logic [14:0] sh;
		logic        rd;
		ascr_byte_t  rd_byte;
	} ascr_frame_t;
	typedef struct packed {
		ascr_angle_t word;
		logic        tog;
	} ascr_rx_t;
	typedef struct packed {
		logic [4:0] cnt;
		logic       bit_out;
		logic       oe_n;
	} ascr_tx_t;
endpackage

/* File: rtl/ascr_spi_link.sv */
// Serial slave shifter running on the link clock
`include "ascr_map.svh"

module ascr_spi_link (
	input  logic                  rst,
	input  logic                  sclk,
	input  logic                  cs_n,
	input  logic                  mosi,
	input  ascr_pkg::ascr_angle_t tx_angle,
	input  ascr_pkg::ascr_byte_t  rd_bias,
	input  ascr_pkg::ascr_byte_t  rd_zero_high,
	input  ascr_pkg::ascr_byte_t  rd_zero_low,
	output logic                  miso,
	output logic                  miso_oe_n,
	output ascr_pkg::ascr_angle_t rx_word,
	output logic                  rx_tog
);
	import ascr_pkg::*;

	ascr_frame_t frame;
	ascr_frame_t next_frame;
	ascr_rx_t    rx;
	ascr_rx_t    next_rx;
	ascr_tx_t    tx;
	ascr_tx_t    next_tx;
	logic        frame_clr;
	logic [7:0]  head;
	ascr_angle_t word;

	// Chip select high ends a frame at once, so short reads leave nothing behind
	assign frame_clr = rst | cs_n;
	assign head      = {frame.sh[6:0], mosi};
	assign word      = frame.rd ? {tx_angle[15:8], frame.rd_byte} : tx_angle;

	always_comb begin
		next_frame = frame;
		next_rx    = rx;
		next_tx    = tx;
		if (frame.cnt != 5'(`ASCR_WORD_BITS)) begin
			next_frame.cnt = frame.cnt + 5'h01;
		end
		next_frame.sh = {frame.sh[13:0], mosi};
		if (frame.cnt == 5'h07) begin
			next_frame.rd = (head[7:4] == `ASCR_OP_READ);
			// Register values only change between frames, so they are stable here
			case (head[3:0])
				`ASCR_ADDR_BIAS:      next_frame.rd_byte = rd_bias;
				`ASCR_ADDR_ZERO_HIGH: next_frame.rd_byte = rd_zero_high;
				`ASCR_ADDR_ZERO_LOW:  next_frame.rd_byte = rd_zero_low & `ASCR_ZERO_LOW_MASK;
				default:              next_frame.rd_byte = `ASCR_REG_RESET;
			endcase
		end
		if (frame.cnt == 5'(`ASCR_WORD_BITS - 1)) begin
			next_rx.word = {frame.sh, mosi};
			next_rx.tog  = ~rx.tog;
		end
		next_tx.oe_n    = 1'b0;
		next_tx.bit_out = tx.cnt[4] ? 1'b0 : word[~tx.cnt[3:0]];
		if (!tx.cnt[4]) begin
			next_tx.cnt = tx.cnt + 5'h01;
		end
	end

	// Three processes: frame state dies with chip select, the finished word must survive it
	always_ff @(posedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			frame <= '0;
		end else begin
			frame <= next_frame;
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rx <= '0;
		end else begin
			rx <= next_rx;
		end
	end

	// Mode 3 sets each bit on the falling edge, the master samples it on the rising one
	always_ff @(negedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			tx <= '{cnt: 5'h00, bit_out: 1'b0, oe_n: 1'b1};
		end else begin
			tx <= next_tx;
		end
	end

	assign miso      = tx.bit_out;
	assign miso_oe_n = tx.oe_n;
	assign rx_word   = rx.word;
	assign rx_tog    = rx.tog;
endmodule // ascr_spi_link

/* File: rtl/ascr_top.sv */
// Top of the angle readout block: settings registers, conditioning and outputs
`include "ascr_map.svh"

module ascr_top #(
	parameter int SAMPLE_CYCLES = `ASCR_SAMPLE_CYCLES
) (
	input  logic                  clk,
	input  logic                  rst,
	input  logic                  sclk,
	input  logic                  cs_n,
	input  logic                  mosi,
	output logic                  miso,
	output logic                  miso_oe_n,
	input  ascr_pkg::ascr_angle_t fe_angle,
	input  logic [2:0]            fuse_stored,
	input  ascr_pkg::ascr_byte_t  fuse_bias,
	input  ascr_pkg::ascr_byte_t  fuse_zero_high,
	input  ascr_pkg::ascr_byte_t  fuse_zero_low,
	output ascr_pkg::ascr_byte_t  bias_trim_amount,
	output logic                  x_axis_trim_enable,
	output logic                  y_axis_trim_enable,
	output ascr_pkg::ascr_angle_t angle_out,
	output logic                  enc_a,
	output logic                  enc_b,
	output logic                  enc_z,
	output logic                  com_u,
	output logic                  com_v,
	output logic                  com_w,
	output logic [2:0]            reg_locked
);
	import ascr_pkg::*;

	ascr_core_t      st;
	ascr_core_t      next;
	ascr_angle_t     rx_word;
	logic            rx_tog;
	logic            mem_en;
	ascr_angle_t     mem_old;
	logic [2:0][7:0] fuse_val;
	logic            word_done;
	logic [3:0]      cmd_op;
	logic [3:0]      cmd_addr;
	ascr_byte_t      cmd_val;
	ascr_angle_t     zero_word;
	ascr_angle_t     diff;
	ascr_angle_t     speed;
	logic [9:0]      enc_cnt;
	logic [9:0]      enc_step;
	logic [18:0]     sector_prod;
	logic [2:0]      sector;

	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------

	ascr_spi_link u_link (
		.rst          (rst),
		.sclk         (sclk),
		.cs_n         (cs_n),
		.mosi         (mosi),
		.tx_angle     (st.out_buf),
		.rd_bias      (st.regs[`ASCR_IDX_BIAS]),
		.rd_zero_high (st.regs[`ASCR_IDX_ZERO_HIGH]),
		.rd_zero_low  (st.regs[`ASCR_IDX_ZERO_LOW]),
		.miso         (miso),
		.miso_oe_n    (miso_oe_n),
		.rx_word      (rx_word),
		.rx_tog       (rx_tog)
	);

	// ----------------------------------------------------------------
	// Sample history for the speed estimate
	// ----------------------------------------------------------------

	ascr_hist_mem #(
		.WIDTH      (`ASCR_WORD_BITS),
		.DEPTH_LOG2 (`ASCR_SPEED_WIN_LOG2)
	) u_hist (
		.clk   (clk),
		.rst   (rst),
		.en    (mem_en),
		.addr  (st.ptr),
		.wdata (fe_angle),
		.rdata (mem_old)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------

	assign fuse_val  = {fuse_zero_low, fuse_zero_high, fuse_bias};
	// The received word is stable for a whole frame after its toggle, so it is read directly
	assign word_done = st.tog_s2 ^ st.tog_seen;
	assign cmd_op    = rx_word[15:12];
	assign cmd_addr  = rx_word[11:8];
	assign cmd_val   = rx_word[7:0];

	// ----------------------------------------------------------------
	// Conditioning arithmetic
	// ----------------------------------------------------------------

	// Offset fills the upper twelve bits so the subtraction wraps modulo one turn
	assign zero_word = {st.regs[`ASCR_IDX_ZERO_HIGH],
		st.regs[`ASCR_IDX_ZERO_LOW][3:0],
		{`ASCR_ZERO_PAD_BITS{1'b0}}};
	assign diff        = st.raw - mem_old;
	// Average step per sample over the window; zero until the window holds real samples
	assign speed       = st.filled ? ascr_angle_t'($signed(diff) >>> `ASCR_SPEED_WIN_LOG2) : '0;
	assign enc_cnt     = st.angle[15:6];
	assign enc_step    = enc_cnt - st.enc_pos;
	assign sector_prod = 19'(st.angle) * 19'(`ASCR_SECTORS);
	assign sector      = sector_prod[18:16];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	always_comb begin
		next   = st;
		mem_en = 1'b0;

		// Chip select and the word toggle come from the link clock
		next.cs_s1    = cs_n;
		next.cs_s2    = st.cs_s1;
		next.tog_s1   = rx_tog;
		next.tog_s2   = st.tog_s1;
		next.tog_seen = st.tog_s2;

		case (st.boot)
			boot_load: begin
				for (int i = 0; i < `ASCR_REG_COUNT; i++) begin
					next.lock[i] = fuse_stored[i];
					next.regs[i] = fuse_stored[i] ? fuse_val[i] : `ASCR_REG_RESET;
				end
				next.boot = boot_run;
			end
			boot_run: begin
				// Any other opcode or address falls through with nothing changed
				if (word_done && cmd_op == `ASCR_OP_WRITE) begin
					for (int i = 0; i < `ASCR_REG_COUNT; i++) begin
						if (cmd_addr == 4'(`ASCR_ADDR_BIAS + i) && !st.lock[i]) begin
							next.regs[i] = cmd_val & ((i == `ASCR_IDX_ZERO_LOW) ?
								`ASCR_ZERO_LOW_MASK : `ASCR_FULL_MASK);
						end
					end
				end
			end
			default: begin
				next.boot = boot_load;
			end
		endcase

		// Front-end sample strobe
		if (st.tick == 12'(SAMPLE_CYCLES - 1)) begin
			next.tick = '0;
			mem_en    = 1'b1;
			next.raw  = fe_angle;
			next.calc = 1'b1;
			next.ptr  = st.ptr + 8'h01;
			if (st.ptr == 8'hFF) begin
				next.filled = 1'b1;
			end
		end else begin
			next.tick = st.tick + 12'h001;
		end

		// One cycle after the strobe the oldest sample is on the memory output
		if (st.calc) begin
			next.est  = st.raw + speed;
			next.calc = 1'b0;
		end

		// Recomputed every cycle so a new offset reaches the outputs at once
		next.angle = st.est - zero_word;

		// Buffer holds still while a frame is running
		if (st.cs_s2) begin
			next.out_buf = st.angle;
		end

		// Quadrature position with one count of hysteresis against jitter
		if (enc_step != 10'h000 && enc_step != 10'h001 && enc_step != 10'h3FF) begin
			if (enc_step[9]) begin
				next.enc_pos = enc_cnt + 10'h001;
			end else begin
				next.enc_pos = enc_cnt - 10'h001;
			end
		end
		next.enc_a = st.enc_pos[1];
		next.enc_b = st.enc_pos[1] ^ st.enc_pos[0];
		// Index follows the true zero, not the hysteresis counter
		next.enc_z = (enc_cnt == 10'h000);

		// Three commutation phases, half duty, one sixth of a turn apart
		next.com_u = (sector < 3'h3);
		next.com_v = (sector >= 3'h1) && (sector < 3'h4);
		next.com_w = (sector >= 3'h2) && (sector < 3'h5);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Trim settings drive the bias circuit unchanged; bit 4 enables the x axis trim, bit 5 the y axis trim
	assign bias_trim_amount   = st.regs[`ASCR_IDX_BIAS];
	assign x_axis_trim_enable = st.regs[`ASCR_IDX_ZERO_LOW][`ASCR_X_TRIM_BIT];
	assign y_axis_trim_enable = st.regs[`ASCR_IDX_ZERO_LOW][`ASCR_Y_TRIM_BIT];
	assign angle_out          = st.angle;
	assign enc_a              = st.enc_a;
	assign enc_b              = st.enc_b;
	assign enc_z              = st.enc_z;
	assign com_u              = st.com_u;
	assign com_v              = st.com_v;
	assign com_w              = st.com_w;
	assign reg_locked         = st.lock;
endmodule // ascr_top

/* File: verification/ascr_props.sv */
// Concurrent checks on the ports of the angle readout top
module ascr_props #(
	parameter int SAMPLE_CYCLES = 200
) (
	input logic                  clk,
	input logic                  rst,
	input logic                  cs_n,
	input logic                  miso,
	input logic                  miso_oe_n,
	input logic [2:0]            fuse_stored,
	input ascr_pkg::ascr_byte_t  fuse_bias,
	input ascr_pkg::ascr_byte_t  bias_trim_amount,
	input logic                  x_axis_trim_enable,
	input logic                  y_axis_trim_enable,
	input ascr_pkg::ascr_angle_t angle_out,
	input logic                  enc_z,
	input logic                  com_u,
	input logic                  com_v,
	input logic                  com_w,
	input logic [2:0]            reg_locked
);
	import ascr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	logic [2:0] sector;
	assign sector = 3'((32'(angle_out) * 32'h6) >> 16);
	oe_idle_a: assert property (cs_n |-> miso_oe_n) else $error("miso enabled while deselected");
	miso_quiet_a: assert property (miso_oe_n |-> !miso) else $error("miso not low while released");
	cs_lead_a: assert property ($fell(cs_n) |-> miso_oe_n [*3]) else $error("miso driven before clock");
	lock_bias_a: assert property (reg_locked[0] && $past(reg_locked[0]) |-> $stable(bias_trim_amount))
		else $error("locked bias trim changed");
	lock_trim_a: assert property (reg_locked[2] && $past(reg_locked[2])
		|-> $stable({x_axis_trim_enable, y_axis_trim_enable})) else $error("locked trim enables changed");
	boot_copy_a: assert property (!$past(rst) && $past(rst, 2) |-> reg_locked == $past(fuse_stored)
		&& bias_trim_amount == (fuse_stored[0] ? fuse_bias : 8'h00)) else $error("boot load wrong");
	phase_map_a: assert property ($stable(angle_out) [*5] |-> {com_u, com_v, com_w} ==
		{sector <= 3'h2, sector >= 3'h1 && sector <= 3'h3, sector >= 3'h2 && sector <= 3'h4})
		else $error("commutation phases disagree with angle");
	zero_mark_a: assert property ($stable(angle_out) [*5] |-> enc_z == (angle_out[15:6] == 10'h000))
		else $error("index mark disagrees with angle");
	cover property ($changed(bias_trim_amount));
	cover property (!miso_oe_n [*8]);
	cover property (enc_z && reg_locked == 3'h7);
endmodule // ascr_props

bind ascr_top ascr_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (
	.clk(clk), .rst(rst), .cs_n(cs_n), .miso(miso), .miso_oe_n(miso_oe_n),
	.fuse_stored(fuse_stored), .fuse_bias(fuse_bias), .bias_trim_amount(bias_trim_amount),
	.x_axis_trim_enable(x_axis_trim_enable), .y_axis_trim_enable(y_axis_trim_enable),
	.angle_out(angle_out), .enc_z(enc_z), .com_u(com_u), .com_v(com_v), .com_w(com_w),
	.reg_locked(reg_locked)
);

/* File: verification/ascr_spi_master.sv */
// Serial master model issuing mode 3 frames to the readout block
module ascr_spi_master (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input  logic miso,
	input  logic miso_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock stands high between frames, it never runs free
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		#7;
		cs_n = 1'b0;
		#80;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = tx[i];
			#40;
			sclk = 1'b1;
			// A released output reads as unknown so it never matches
			rx[i] = miso_oe_n ? 1'bx : miso;
			#40;
		end
		cs_n = 1'b1;
		// Undriven line: show the inverse rather than a stale level
		mosi = ~mosi;
		#200;
	endtask
endmodule // ascr_spi_master

/* File: verification/ascr_tb.sv */
// Self-checking bench of the angle readout block
module ascr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ascr_pkg::*;
	localparam int SMP = 20;
	localparam logic [7:0] TRIMS [3] = '{8'h10, 8'h20, 8'hFF};
	logic clk, rst, sclk, cs_n, mosi, miso, miso_oe_n;
	logic x_axis_trim_enable, y_axis_trim_enable, enc_a, enc_b, enc_z, com_u, com_v, com_w;
	logic [2:0] fuse_stored, reg_locked;
	ascr_byte_t fuse_bias, fuse_zero_high, fuse_zero_low, bias_trim_amount;
	ascr_angle_t fe_angle, angle_out;
	int n_fail, compares, cyc;

	ascr_top #(.SAMPLE_CYCLES(SMP)) dut (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
		.fe_angle(fe_angle), .fuse_stored(fuse_stored), .fuse_bias(fuse_bias),
		.fuse_zero_high(fuse_zero_high), .fuse_zero_low(fuse_zero_low), .bias_trim_amount(bias_trim_amount),
		.x_axis_trim_enable(x_axis_trim_enable), .y_axis_trim_enable(y_axis_trim_enable),
		.angle_out(angle_out), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
		.com_u(com_u), .com_v(com_v), .com_w(com_w), .reg_locked(reg_locked)
	);
	ascr_spi_master u_m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));

	always #5 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] regs();
		return {bias_trim_amount, 3'b000, y_axis_trim_enable, x_axis_trim_enable, reg_locked};
	endfunction
	task automatic xchk(input logic [15:0] w, input logic [15:0] e);
		logic [15:0] r;
		u_m.xfer(w, r);
		check(r, e);
	endtask
	task automatic do_reset(input logic [2:0] fs);
		@(posedge clk);
		fuse_stored <= fs;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Wait for a few samples so angle_out carries the front end
		repeat (SMP * 3) @(posedge clk);
	endtask
	task automatic conclude;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		do_reset(3'b000);
		check(regs(), 16'h0000);
		check(angle_out, 16'h1234);
		xchk(16'h0000, 16'h1234);
	endtask
	task automatic t_write;
		xchk(16'h23A5, 16'h1234);
		repeat (10) @(posedge clk);
		check(regs(), 16'hA500);
		xchk(16'h13CC, 16'h12A5);
		xchk(16'h0000, 16'h1234);
		xchk(16'h2423, 16'h1234);
		xchk(16'h0000, 16'hEF34);
		check(angle_out, 16'hEF34);
		foreach (TRIMS[i]) begin
			xchk({8'h25, TRIMS[i]}, 16'hEF34);
			repeat (10) @(posedge clk);
			check(regs(), {8'hA5, 3'b000, TRIMS[i][5], TRIMS[i][4], 3'b000});
		end
		xchk(16'h15AA, 16'hEE3F);
		xchk(16'h1400, 16'hEE23);
		xchk(16'h1700, 16'hEE00);
		xchk(16'h2777, 16'hEE44);
		xchk(16'h3355, 16'hEE44);
		repeat (10) @(posedge clk);
		check(regs(), 16'hA518);
	endtask
	task automatic t_fuse;
		do_reset(3'b111);
		check(regs(), 16'h5A1F);
		check(angle_out, 16'h0024);
		xchk(16'h2300, 16'h0024);
		xchk(16'h2400, 16'h0024);
		xchk(16'h2500, 16'h0024);
		repeat (10) @(posedge clk);
		check(regs(), 16'h5A1F);
		xchk(16'h1400, 16'h0012);
		check(16'({enc_z, com_u, com_v, com_w}), 16'h000C);
	endtask
	task automatic t_track;
		// Let the speed window fill with the resting angle before stepping
		repeat (256 * SMP) @(posedge clk);
		fe_angle <= 16'h1334;
		repeat (SMP + 6) @(posedge clk);
		check(angle_out, 16'h0125);
		check(16'({enc_z, enc_a, enc_b, com_u, com_v, com_w}), 16'h0014);
		// Once the whole window holds the new angle the lead term falls away
		repeat (260 * SMP) @(posedge clk);
		check(angle_out, 16'h0124);
		fe_angle <= 16'h1234;
		repeat (SMP + 6) @(posedge clk);
		check(angle_out, 16'h0023);
		check(16'({enc_z, enc_a, enc_b, com_u, com_v, com_w}), 16'h002C);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			conclude;
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		fe_angle = 16'h1234;
		fuse_stored = 3'b000;
		fuse_bias = 8'h5A;
		fuse_zero_high = 8'h12;
		fuse_zero_low = 8'h31;
		n_fail = 0;
		compares = 0;
		cyc = 0;
		t_reset;
		t_write;
		t_fuse;
		t_track;
		conclude;
	end
endmodule // ascr_tb
